// file: bench/dsr_regs_chk.sv
// checker: port-level assertions for the register slice
// assumes: bound into dsr_regs; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module dsr_regs_chk (
  input wire logic                  I_SYS_CLK,
  input wire logic                  I_RESETN,
  input wire dsr_pkg::dsr_apb_req_t I_APB,
  input wire dsr_pkg::dsr_apb_rsp_t O_APB,
  input wire dsr_pkg::dsr_rmt_wr_t  O_RMT_WR,
  input wire logic                  I_RMT_ACK,
  input wire logic                  O_SCL_OUT,
  input wire logic                  O_SCL_OE_N,
  input wire logic                  O_TGT_RELEASE,
  input wire dsr_pkg::dsr_dp_out_t  O_DP,
  input wire logic                  O_AUD_SURR_SD
);
  import dsr_pkg::*;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  sequence s_setup;
    I_APB.psel && !I_APB.penable;
  endsequence
  sequence s_rmt_wait;
    O_RMT_WR.req && !I_RMT_ACK;
  endsequence
  chk_ready_next: assert property (s_setup |=> O_APB.pready)
    else $error("pready missing after setup");
  chk_err_zero: assert property (O_APB.pslverr |-> O_APB.prdata == 32'h0)
    else $error("refused access returned data");
  chk_upper_zero: assert property (O_APB.pready |-> O_APB.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_rmt_addr: assert property (O_RMT_WR.req |-> O_RMT_WR.addr == 8'h14 && O_RMT_WR.data[7:2] == 6'h0)
    else $error("remote write has wrong offset or data");
  chk_rmt_hold: assert property (s_rmt_wait |=> O_RMT_WR.req && $stable(O_RMT_WR))
    else $error("remote write dropped before ack");
  chk_rmt_done: assert property (O_RMT_WR.req && I_RMT_ACK |=> !O_RMT_WR.req)
    else $error("remote write held after ack");
  chk_ctrl_on: assert property ($past(I_RESETN) |-> O_DP.ctrl_ch_on)
    else $error("control channel off");
  chk_surr_off: assert property (!O_DP.surround |-> !O_AUD_SURR_SD)
    else $error("surround audio out while disabled");
  chk_release_oe: assert property (O_TGT_RELEASE |-> O_SCL_OE_N)
    else $error("scl still held at release");
  chk_release_pulse: assert property (O_TGT_RELEASE |=> !O_TGT_RELEASE)
    else $error("release pulse too long");
  chk_scl_drive: assert property (!O_SCL_OUT)
    else $error("scl driven high");
endmodule : dsr_regs_chk
bind dsr_regs dsr_regs_chk i_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_APB(I_APB), .O_APB(O_APB),
  .O_RMT_WR(O_RMT_WR), .I_RMT_ACK(I_RMT_ACK), .O_SCL_OUT(O_SCL_OUT),
  .O_SCL_OE_N(O_SCL_OE_N), .O_TGT_RELEASE(O_TGT_RELEASE), .O_DP(O_DP),
  .O_AUD_SURR_SD(O_AUD_SURR_SD));
`default_nettype wire

// file: bench/dsr_rmt_model.sv
// remote serializer stand-in: takes config writes, acks after a delay
// assumes: same clock as the slice; request held until acked
`timescale 1ns/1ps
`default_nettype none
module dsr_rmt_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire dsr_pkg::dsr_rmt_wr_t i_wr,
  input  wire logic [3:0]           i_dly,
  output logic                      o_ack,
  output logic [7:0]                o_clk_src,
  output logic [7:0]                o_n_wr
);
  import dsr_pkg::*;
  logic [3:0] wait_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack     <= 1'b0;
      o_clk_src <= 8'h00;
      o_n_wr    <= 8'h00;
      wait_q    <= 4'h0;
    end else begin
      o_ack <= 1'b0;
      if (i_wr.req && !o_ack) begin
        if (wait_q >= i_dly) begin
          o_ack  <= 1'b1;
          wait_q <= 4'h0;
          o_n_wr <= o_n_wr + 8'h01;
          // only the clock source offset is modelled
          if (i_wr.addr == 8'h14) o_clk_src <= i_wr.data;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : dsr_rmt_model
`default_nettype wire

// file: bench/tb.sv
// top bench: apb driver, remote model and directed scenarios
// assumes: dsr_regs, its checker and the remote model compiled before
`timescale 1ns/1ps
`default_nettype none
`include "dsr_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import dsr_pkg::*;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  dsr_apb_req_t req = '0;
  dsr_apb_rsp_t rsp;
  dsr_rmt_wr_t  rmt;
  dsr_dp_out_t  dp;
  logic         ack, irq, st_en, scl_oe_n, scl_out, rel, aud, saud, err;
  logic [1:0]   st_err = 2'b00, gpio_o, gpio_i = 2'b10;
  logic         run = 1'b0, hold = 1'b0, rdy = 1'b0, fc_ld = 1'b0, auto = 1'b0, pin = 1'b0;
  logic         wclk = 1'b0, sd = 1'b1, ssd = 1'b1;
  logic [7:0]   fc_d = 8'h00, src, n_wr;
  logic [3:0]   dly = 4'h0;
  logic [31:0]  rd;
  int           fails = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  dsr_regs i_dut (
    .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_APB(req), .O_APB(rsp), .O_IRQ(irq),
    .I_SELFTEST_PIN(pin), .O_SELFTEST_EN(st_en), .O_RMT_WR(rmt), .I_RMT_ACK(ack),
    .I_ST_ERR(st_err), .I_CTRL_RUN(run), .I_SCL_IN(scl_oe_n), .O_SCL_OUT(scl_out),
    .O_SCL_OE_N(scl_oe_n), .I_TGT_HOLD(hold), .I_TGT_DATA_RDY(rdy), .O_TGT_RELEASE(rel),
    .I_FC_LOAD(fc_ld), .I_FC_DATA(fc_d), .I_AUTO_DETECT(auto), .I_FORCE_TWO_LANE(1'b0),
    .O_DP(dp), .I_GPIO_OUT(gpio_i), .I_AUD_WCLK(wclk), .I_AUD_SD(sd),
    .I_AUD_SURR_SD(ssd), .O_GPIO(gpio_o), .O_AUD_SD(aud), .O_AUD_SURR_SD(saud));
  dsr_rmt_model i_rmt (
    .i_clk(clk), .i_rst_n(rst_n), .i_wr(rmt), .i_dly(dly), .o_ack(ack),
    .o_clk_src(src), .o_n_wr(n_wr));
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {2'b00, idx, 2'b00}, pwdata: {24'h0, d}};
    @(posedge clk) req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 16);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (n >= 16) fails++;
  endtask : apb
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, {24'h0, exp})
  endtask : rdc
  task automatic t_reset();
    rdc(`DSR_IDX_STCTL, 8'h08);
    rdc(`DSR_IDX_TALLY, 8'h00);
    rdc(`DSR_IDX_SCLHI, 8'h83);
    rdc(`DSR_IDX_SCLLO, 8'h84);
    rdc(`DSR_IDX_DPCFG, 8'h20);
    `CHK({dp.video_off, dp.ctrl_ch_on}, 2'b11)
    apb(1'b0, 8'hFF, 8'h00);
    `CHK(err, 1'b1)
    $display("test reset done");
  endtask : t_reset
  task automatic t_selftest();
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(st_en, 1'b1)
    for (int i = 0; i < 2; i++) begin
      dly <= i ? 4'h6 : 4'h0; // prompt remote first, then a slow one
      apb(1'b1, `DSR_IDX_STCTL, 8'h00);
      repeat (2) @(posedge clk);
      `CHK(st_en, 1'b0)
      apb(1'b1, `DSR_IDX_STCTL, i ? 8'h03 : 8'h05);
      for (int k = 0; k < 30 && n_wr !== 8'(i + 2); k++) @(posedge clk);
      `CHK(st_en, 1'b1)
      `CHK(src, i ? 8'h01 : 8'h02)
    end
    st_err <= 2'b10;
    @(posedge clk) st_err <= 2'b11;
    @(posedge clk) st_err <= 2'b00;
    rdc(`DSR_IDX_TALLY, 8'h01);
    apb(1'b1, `DSR_IDX_RXPC, 8'h08);
    apb(1'b1, `DSR_IDX_TALLY, 8'hAA);
    rdc(`DSR_IDX_TALLY, 8'h02);
    `CHK(irq, 1'b0)
    apb(1'b1, `DSR_IDX_IRQMSK, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    rdc(`DSR_IDX_IRQST, 8'h05);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rdc(`DSR_IDX_IRQST, 8'h00);
    $display("test selftest done");
  endtask : t_selftest
  task automatic t_scl();
    int nl = 0;
    int nh = 0;
    apb(1'b1, `DSR_IDX_SCLHI, 8'h07);
    apb(1'b1, `DSR_IDX_SCLLO, 8'h09);
    run <= 1'b1;
    for (int k = 0; k < 500 && scl_oe_n !== 1'b0; k++) @(posedge clk);
    while (scl_oe_n === 1'b0 && nl < 500) begin
      @(posedge clk);
      nl++;
    end
    while (scl_oe_n === 1'b1 && nh < 500) begin
      @(posedge clk);
      nh++;
    end
    run <= 1'b0;
    `CHK(nl, 9)
    `CHK(nh >= 7 && nh <= 10, 1'b1)
    for (int k = 0; k < 500 && scl_oe_n !== 1'b1; k++) @(posedge clk);
    hold <= 1'b1;
    @(posedge clk) hold <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(scl_oe_n, 1'b0)
    rdy <= 1'b1;
    @(posedge clk) rdy <= 1'b0;
    nl = 0;
    while (rel !== 1'b1 && nl < 40) begin
      @(posedge clk);
      nl++;
    end
    `CHK(nl >= 9 && nl <= 11, 1'b1)
    $display("test scl done");
  endtask : t_scl
  task automatic t_dp();
    apb(1'b1, `DSR_IDX_DPCFG, 8'hFF);
    rdc(`DSR_IDX_DPCFG, 8'hBF);
    `CHK({dp.video_off, dp.video28, dp.surround}, 3'b111)
    `CHK({gpio_o, aud, saud}, 4'b0100)
    fc_ld <= 1'b1;
    @(posedge clk) fc_ld <= 1'b0;
    rdc(`DSR_IDX_DPCFG, 8'hBF);
    apb(1'b1, `DSR_IDX_DPCFG, 8'h01);
    repeat (2) @(posedge clk);
    `CHK({gpio_o, aud, saud, dp.video28}, 5'b10110)
    auto <= 1'b1;
    fc_d <= 8'h16;
    fc_ld <= 1'b1;
    @(posedge clk) fc_ld <= 1'b0;
    rdc(`DSR_IDX_DPCFG, 8'h16);
    `CHK({dp.video_on, dp.video_off, dp.two_lane_rx}, 3'b101)
    $display("test datapath done");
  endtask : t_dp
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_selftest();
    t_scl();
    t_dp();
    finish_test();
  end
endmodule : tb
`default_nettype wire

// file: core/dsr_defs.svh
// register map, field positions, reset values and timing counts
// assumes: included by bare name, one 10 MHz system clock
`ifndef DSR_DEFS_SVH
`define DSR_DEFS_SVH
// register indices; byte address is four times the index
`define DSR_IDX_STCTL   8'h24
`define DSR_IDX_TALLY   8'h25
`define DSR_IDX_SCLHI   8'h26
`define DSR_IDX_SCLLO   8'h27
`define DSR_IDX_DPCFG   8'h28
`define DSR_IDX_RXPC    8'h34
`define DSR_IDX_IRQST   8'h38
`define DSR_IDX_IRQMSK  8'h39
// reset values
`define DSR_RST_STCTL   8'h08
`define DSR_RST_TALLY   8'h00
`define DSR_RST_SCLHI   8'h83
`define DSR_RST_SCLLO   8'h84
`define DSR_RST_DPCFG   8'h20
`define DSR_RST_RXPC    8'h00
`define DSR_RST_IRQMSK  4'h0
// writable masks; reserved bits stay zero
`define DSR_WMSK_DPCFG  8'hBF
`define DSR_WMSK_RXPC   8'h08
// fields
`define DSR_ST_EN       0
`define DSR_ST_SRC_HI   2
`define DSR_ST_SRC_LO   1
`define DSR_ST_PINCFG   3
`define DSR_DP_KEEP     7
`define DSR_DP_VOFF     5
`define DSR_DP_TWOLN    4
`define DSR_DP_ALTAUD   3
`define DSR_DP_AUDOFF   2
`define DSR_DP_VID28    1
`define DSR_DP_SURR     0
`define DSR_RXPC_P1SEL  3
// interrupt status bits
`define DSR_IRQ_STERR   0
`define DSR_IRQ_FCLOAD  1
`define DSR_IRQ_RMTDONE 2
`define DSR_IRQ_TGTREL  3
// remote serializer clock source offset
`define DSR_RMT_CLKSRC  8'h14
// timing
`define DSR_TICK_NS     50
`define DSR_CLK_NS      100
`define DSR_TICK_CYC    ((`DSR_TICK_NS + `DSR_CLK_NS - 1) / `DSR_CLK_NS)
`endif

// file: core/dsr_pkg.sv
// types shared by the register slice
// assumes: constants come from dsr_defs.svh
package dsr_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dsr_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dsr_apb_rsp_t;
  typedef struct packed {
    logic       req;
    logic [7:0] addr;
    logic [7:0] data;
  } dsr_rmt_wr_t;
  typedef struct packed {
    logic video_on;
    logic video_off;
    logic ctrl_ch_on;
    logic two_lane_rx;
    logic video28;
    logic surround;
  } dsr_dp_out_t;
  typedef enum logic [1:0] {SCL_IDLE, SCL_HIGH, SCL_LOW} dsr_scl_st_t;
endpackage : dsr_pkg

// file: core/dsr_regs.sv
// deserializer self-test, i2c scl timing and datapath register slice
// assumes: apb master on I_SYS_CLK; link, audio and i2c target logic on the same clock;
// only I_SELFTEST_PIN and I_SCL_IN come from outside and are synchronised here
//
// How it works
// - self-test enable copies clock source to remote
// - bit 0 starts self-test, resets to zero
// - error tally shows port picked by selector
// - scl high lasts high width ticks
// - high width resets to 0x83
// - scl low lasts low width, reset 0x84
// - target uses low width as setup delay
// - keep-local bit blocks forward channel reload
// - bit 5 flags no video, control stays up
// - bit 4 gives lane mode for auto-detect
// - bit 3 routes audio onto gpio pins
// - bit 2 switches serial audio off except on gpio0
// - bit 1 selects 28-bit video
// - bit 0 enables surround audio
// - pin-config zero uses register self-test bits
//
// Local design decision: the APB interface to the registers.
`include "dsr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dsr_regs (
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_RESETN,
  input  wire dsr_pkg::dsr_apb_req_t I_APB,
  output var  dsr_pkg::dsr_apb_rsp_t O_APB,
  output logic                      O_IRQ,
  input  wire logic                 I_SELFTEST_PIN,
  output logic                      O_SELFTEST_EN,
  output var  dsr_pkg::dsr_rmt_wr_t O_RMT_WR,
  input  wire logic                 I_RMT_ACK,
  input  wire logic [1:0]           I_ST_ERR,
  input  wire logic                 I_CTRL_RUN,
  input  wire logic                 I_SCL_IN,
  output logic                      O_SCL_OUT,
  output logic                      O_SCL_OE_N,
  input  wire logic                 I_TGT_HOLD,
  input  wire logic                 I_TGT_DATA_RDY,
  output logic                      O_TGT_RELEASE,
  input  wire logic                 I_FC_LOAD,
  input  wire logic [7:0]           I_FC_DATA,
  input  wire logic                 I_AUTO_DETECT,
  input  wire logic                 I_FORCE_TWO_LANE,
  output var  dsr_pkg::dsr_dp_out_t O_DP,
  input  wire logic [1:0]           I_GPIO_OUT,
  input  wire logic                 I_AUD_WCLK,
  input  wire logic                 I_AUD_SD,
  input  wire logic                 I_AUD_SURR_SD,
  output logic [1:0]                O_GPIO,
  output logic                      O_AUD_SD,
  output logic                      O_AUD_SURR_SD
);
  import dsr_pkg::*;

  logic [7:0]  stctl_q;
  logic [7:0]  sclhi_q;
  logic [7:0]  scllo_q;
  logic [7:0]  dpcfg_q;
  logic [7:0]  rxpc_q;
  logic [3:0]  irq_st_q;
  logic [3:0]  irq_msk_q;
  logic [3:0]  irq_set;
  logic [7:0]  tally_q [2];
  logic [1:0]  pin_sync_q;
  logic [1:0]  scl_sync_q;
  logic        st_en_prev_q;
  logic        st_en_eff;
  logic [1:0]  st_src_eff;
  logic        st_start;
  logic [7:0]  idx;
  logic        addr_ok;
  logic        wr_en;
  logic        rd_clr;
  logic [7:0]  rd_val;
  logic        hit;
  logic [3:0]  tick_cnt_q;
  logic        tick;
  dsr_scl_st_t scl_st_q;
  logic [7:0]  scl_cnt_q;
  logic        tgt_hold_q;
  logic        tgt_run_q;
  logic [7:0]  tgt_cnt_q;
  logic        tgt_done;

  // apb decode; only word-aligned addresses are mapped
  assign idx     = I_APB.paddr[9:2];
  assign addr_ok = (I_APB.paddr[1:0] == 2'h0) && (I_APB.paddr[11:10] == 2'h0);
  assign wr_en   = I_APB.psel && I_APB.penable && I_APB.pwrite && O_APB.pready;
  // the clear uses the word already returned, so later events are kept
  assign rd_clr  = I_APB.psel && I_APB.penable && !I_APB.pwrite && O_APB.pready &&
                   (idx == `DSR_IDX_IRQST) && addr_ok;

  always_comb begin
    hit    = addr_ok;
    rd_val = 8'h00;
    case (idx)
      `DSR_IDX_STCTL:  rd_val = stctl_q;
      `DSR_IDX_TALLY:  rd_val = tally_q[rxpc_q[`DSR_RXPC_P1SEL]];
      `DSR_IDX_SCLHI:  rd_val = sclhi_q;
      `DSR_IDX_SCLLO:  rd_val = scllo_q;
      `DSR_IDX_DPCFG:  rd_val = dpcfg_q;
      `DSR_IDX_RXPC:   rd_val = rxpc_q;
      `DSR_IDX_IRQST:  rd_val = {4'h0, irq_st_q};
      `DSR_IDX_IRQMSK: rd_val = {4'h0, irq_msk_q};
      default:         hit = 1'b0;
    endcase
  end

  // zero-wait slave: data latched in setup, pready in the single access cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_APB <= '0;
    end else if (I_APB.psel && !I_APB.penable && !O_APB.pready) begin
      O_APB.pready  <= 1'b1;
      O_APB.pslverr <= !hit;
      O_APB.prdata  <= hit ? {24'h000000, rd_val} : 32'h00000000;
    end else begin
      O_APB.pready  <= 1'b0;
      O_APB.pslverr <= 1'b0;
    end
  end

  // control registers; tally is read-only so has no write path
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      stctl_q   <= `DSR_RST_STCTL;
      sclhi_q   <= `DSR_RST_SCLHI;
      scllo_q   <= `DSR_RST_SCLLO;
      rxpc_q    <= `DSR_RST_RXPC;
      irq_msk_q <= `DSR_RST_IRQMSK;
    end else if (wr_en && addr_ok) begin
      case (idx)
        // bits 7:4 are only stored; nothing in this slice reads them
        `DSR_IDX_STCTL:  stctl_q   <= I_APB.pwdata[7:0];
        // no floor enforced; values under 0x07 are software's fault
        `DSR_IDX_SCLHI:  sclhi_q   <= I_APB.pwdata[7:0];
        `DSR_IDX_SCLLO:  scllo_q   <= I_APB.pwdata[7:0];
        `DSR_IDX_RXPC:   rxpc_q    <= I_APB.pwdata[7:0] & `DSR_WMSK_RXPC;
        `DSR_IDX_IRQMSK: irq_msk_q <= I_APB.pwdata[3:0];
        default: ;
      endcase
    end
  end

  // datapath config: local write tested first, so it wins over a forward channel reload the same cycle
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      dpcfg_q <= `DSR_RST_DPCFG;
    end else if (wr_en && addr_ok && idx == `DSR_IDX_DPCFG) begin
      dpcfg_q <= I_APB.pwdata[7:0] & `DSR_WMSK_DPCFG;
    end else if (I_FC_LOAD && !dpcfg_q[`DSR_DP_KEEP]) begin
      dpcfg_q <= {dpcfg_q[7], 1'b0, I_FC_DATA[5:0]};
    end
  end

  // two-flop synchronisers for pins
  // scl resets high like the idle pulled-up line, so no false low after reset
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      pin_sync_q <= 2'h0;
      scl_sync_q <= 2'h3;
    end else begin
      pin_sync_q <= {pin_sync_q[0], I_SELFTEST_PIN};
      scl_sync_q <= {scl_sync_q[0], I_SCL_IN};
    end
  end

  // pin mode takes enable from the strap pin, clock source defaults to zero
  assign st_en_eff  = stctl_q[`DSR_ST_PINCFG] ? pin_sync_q[1]
                                              : stctl_q[`DSR_ST_EN];
  assign st_src_eff = stctl_q[`DSR_ST_PINCFG] ? 2'h0
                      : stctl_q[`DSR_ST_SRC_HI:`DSR_ST_SRC_LO];
  assign st_start   = st_en_eff && !st_en_prev_q;
  // previous value resets low like the enable, so reset makes no false start

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_en_prev_q  <= 1'b0;
      O_SELFTEST_EN <= 1'b0;
    end else begin
      st_en_prev_q  <= st_en_eff;
      O_SELFTEST_EN <= st_en_eff;
    end
  end

  // remote write held until the link acknowledges it
  // a new start while one is pending replaces it; only the latest source matters
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RMT_WR <= '0;
    end else if (st_start) begin
      O_RMT_WR.req  <= 1'b1;
      O_RMT_WR.addr <= `DSR_RMT_CLKSRC;
      O_RMT_WR.data <= {6'h00, st_src_eff};
    end else if (I_RMT_ACK) begin
      O_RMT_WR.req <= 1'b0;
    end
  end

  // per-port error tallies, cleared at each self-test start, saturating
  // saturating keeps a long run from wrapping back to a clean-looking count
  for (genvar p = 0; p < 2; p++) begin : g_tally
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        tally_q[p] <= `DSR_RST_TALLY;
      end else if (st_start) begin
        tally_q[p] <= `DSR_RST_TALLY;
      end else if (st_en_eff && I_ST_ERR[p] && tally_q[p] != 8'hFF) begin
        tally_q[p] <= tally_q[p] + 8'h01;
      end
    end
  end

  // the clock is slower than the 50 ns tick, so a tick spans a whole cycle
  // and scl widths come out twice the nominal time; accepted, no faster clock
  // exists here, and the divider stays so a faster clock only edits the count
  assign tick = (tick_cnt_q == 4'(`DSR_TICK_CYC - 1));

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tick_cnt_q <= 4'h0;
    end else if (tick) begin
      tick_cnt_q <= 4'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 4'h1;
    end
  end

  // controller scl: high phase waits while a target stretches the line
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      scl_st_q  <= SCL_IDLE;
      scl_cnt_q <= 8'h00;
    end else begin
      case (scl_st_q)
        SCL_IDLE: begin
          if (I_CTRL_RUN && !tgt_hold_q) begin
            scl_st_q  <= SCL_HIGH;
            scl_cnt_q <= sclhi_q;
          end
        end
        SCL_HIGH: begin
          // a stretching target freezes the count until the line reads high
          if (tick && scl_sync_q[1]) begin
            if (scl_cnt_q <= 8'h01) begin
              scl_st_q  <= SCL_LOW;
              scl_cnt_q <= scllo_q;
            end else begin
              scl_cnt_q <= scl_cnt_q - 8'h01;
            end
          end
        end
        SCL_LOW: begin
          if (tick) begin
            if (scl_cnt_q <= 8'h01) begin
              scl_st_q  <= I_CTRL_RUN ? SCL_HIGH : SCL_IDLE;
              scl_cnt_q <= sclhi_q;
            end else begin
              scl_cnt_q <= scl_cnt_q - 8'h01;
            end
          end
        end
        default: scl_st_q <= SCL_IDLE;
      endcase
    end
  end

  // target stretch: after data is ready, wait the low width then let scl go
  // the release pulse and the dropped hold leave in the same registered cycle
  assign tgt_done = tgt_run_q && tick && (tgt_cnt_q <= 8'h01);

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tgt_hold_q    <= 1'b0;
      tgt_run_q     <= 1'b0;
      tgt_cnt_q     <= 8'h00;
      O_TGT_RELEASE <= 1'b0;
    end else begin
      O_TGT_RELEASE <= tgt_done;
      if (tgt_done) begin
        tgt_hold_q <= 1'b0;
        tgt_run_q  <= 1'b0;
      end else if (tgt_run_q && tick) begin
        tgt_cnt_q <= tgt_cnt_q - 8'h01;
      end else if (tgt_hold_q && I_TGT_DATA_RDY && !tgt_run_q) begin
        tgt_run_q <= 1'b1;
        tgt_cnt_q <= scllo_q;
      end else if (I_TGT_HOLD) begin
        tgt_hold_q <= 1'b1;
      end
    end
  end

  // open drain: only ever pulls low
  // releasing the enable lets the pull-up raise the line
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SCL_OUT  <= 1'b0;
      O_SCL_OE_N <= 1'b1;
    end else begin
      O_SCL_OUT  <= 1'b0;
      O_SCL_OE_N <= !((scl_st_q == SCL_LOW) || (tgt_hold_q && !tgt_done));
    end
  end

  // datapath outputs
  // control channel stays up whatever the video bit says
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_DP <= '0;
    end else begin
      O_DP.video_off   <= dpcfg_q[`DSR_DP_VOFF];
      O_DP.video_on    <= !dpcfg_q[`DSR_DP_VOFF];
      O_DP.ctrl_ch_on  <= 1'b1;
      O_DP.two_lane_rx <= I_AUTO_DETECT ? dpcfg_q[`DSR_DP_TWOLN]
                                        : I_FORCE_TWO_LANE;
      O_DP.video28     <= dpcfg_q[`DSR_DP_VID28];
      O_DP.surround    <= dpcfg_q[`DSR_DP_SURR];
    end
  end

  // audio routing; gpio1 carries word clock, gpio0 serial data
  // surround also obeys audio-off, so one write silences O_AUD_SD and O_AUD_SURR_SD but not serial data routed to gpio0
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_GPIO        <= 2'h0;
      O_AUD_SD      <= 1'b0;
      O_AUD_SURR_SD <= 1'b0;
    end else begin
      O_GPIO        <= dpcfg_q[`DSR_DP_ALTAUD] ? {I_AUD_WCLK, I_AUD_SD}
                                               : I_GPIO_OUT;
      O_AUD_SD      <= I_AUD_SD && !dpcfg_q[`DSR_DP_AUDOFF];
      O_AUD_SURR_SD <= I_AUD_SURR_SD && !dpcfg_q[`DSR_DP_AUDOFF]
                       && dpcfg_q[`DSR_DP_SURR];
    end
  end

  // sticky status, read clears; a new event in the clearing cycle survives
  assign irq_set[`DSR_IRQ_STERR]   = st_en_eff && (I_ST_ERR != 2'h0);
  assign irq_set[`DSR_IRQ_FCLOAD]  = I_FC_LOAD && !dpcfg_q[`DSR_DP_KEEP];
  assign irq_set[`DSR_IRQ_RMTDONE] = O_RMT_WR.req && I_RMT_ACK;
  assign irq_set[`DSR_IRQ_TGTREL]  = tgt_done;

  // one sticky bit per event; set is tested first so it wins over the clear
  for (genvar b = 0; b < 4; b++) begin : g_irq
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        irq_st_q[b] <= 1'b0;
      end else if (irq_set[b]) begin
        irq_st_q[b] <= 1'b1;
      end else if (rd_clr && O_APB.prdata[b]) begin
        irq_st_q[b] <= 1'b0;
      end
    end
  end

  // level interrupt, one cycle behind the status it summarises
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(irq_st_q & irq_msk_q);
    end
  end

endmodule : dsr_regs
`default_nettype wire
